// ===== common/frr_pkg.sv
// Purpose: constants for the fault response and retry control block
// Assumes: 10 MHz reference clock
// Notes:   response byte layout, codes and the pin propagation mask
package frr_pkg;

  // --------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned RETRY_UNIT_US   = 1000;
  localparam int unsigned RETRY_UNIT_CYC  =
    (CLK_HZ / 1000000) * RETRY_UNIT_US;

  // --------------------------------------------------------------------
  // command codes
  // --------------------------------------------------------------------
  localparam logic [7:0]  CMD_PROP_MASK   = 8'hD2;

  // --------------------------------------------------------------------
  // response byte fields
  // --------------------------------------------------------------------
  localparam int unsigned RESP_MSB        = 7;
  localparam int unsigned RESP_LSB        = 6;
  localparam int unsigned RETRY_MSB       = 5;
  localparam int unsigned RETRY_LSB       = 3;
  localparam logic [1:0]  RESP_CONTINUE   = 2'h0;
  localparam logic [1:0]  RESP_SHUTDOWN   = 2'h2;
  localparam logic [2:0]  RETRY_NONE      = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
  localparam logic [7:0]  RESP_RESET      = 8'h80;

  // --------------------------------------------------------------------
  // propagation mask
  // --------------------------------------------------------------------
  localparam logic [15:0] PROP_MASK_RESET = 16'h2993;

  typedef enum logic [1:0] {
    FRR_RUN,
    FRR_OFF,
    FRR_WAIT
  } frr_state_e;

endpackage

// ===== logic/frr_retry_timer.sv
// Purpose: retry interval counter, counts delay units between restarts
// Assumes: i_unit_tick is a one-cycle pulse per delay unit
// Notes:   o_done pulses once when the loaded interval has elapsed
`timescale 1ns/100ps
module frr_retry_timer (
  input  wire logic        i_ref_clk,   // clock
  input  wire logic        i_rst,       // sync reset
  input  wire logic        i_load,      // start a new interval
  input  wire logic [15:0] i_units,     // interval in delay units
  input  wire logic        i_unit_tick, // unit enable pulse
  output logic             o_done       // interval elapsed pulse
);
  logic [15:0] cnt_ff;
  logic        run_ff;
  logic        done_ff;
  // one tick beyond the count, so the wait never falls short of the
  // interval whatever the phase of the free-running unit divider
  wire         last = run_ff && i_unit_tick && (cnt_ff == 16'h0000);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_ff  <= 16'h0000;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      // a reload drops the end of an older interval
      done_ff <= last && !i_load;
      if (i_load) begin
        cnt_ff <= i_units;
        run_ff <= 1'b1;
      end else if (last) begin
        run_ff <= 1'b0;
      end else if (run_ff && i_unit_tick) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end

  assign o_done = done_ff;
endmodule

// ===== logic/frr_fault_ctrl.sv
// Behaviour
// - response continue keeps output regulating
// - response codes 01 and 11 flag fault
// - shutdown code disables output, then retry policy
// - any fault sets latched status flag
// - any fault drives alert active
// - flag held until clear, off/on, or reset
// - no retry keeps output off until clear or off/on
// - unlimited retry restarts until commanded off
// - restart spacing from separate retry delay
// - low three bits of response ignored
// - 16-bit pin propagation mask, default loaded
//
// Purpose: fault response, retry and pin propagation for one fault input
// Assumes: command decode upstream delivers write strobes with data
// Notes:   fault inputs come from analog comparators, so they are synced
`timescale 1ns/100ps
module frr_fault_ctrl (
  input  wire logic        i_ref_clk,      // 10 MHz clock
  input  wire logic        i_rst,          // sync reset, active high
  input  wire logic        i_resp_wr,      // response byte write strobe
  input  wire logic [7:0]  i_resp_wdata,   // response byte data
  input  wire logic        i_cmd_wr,       // word command write strobe
  input  wire logic [7:0]  i_cmd_code,     // command code
  input  wire logic [15:0] i_cmd_wdata,    // word command data
  input  wire logic        i_nvm_load,     // restore mask from nvm
  input  wire logic [15:0] i_nvm_mask,     // stored mask value
  input  wire logic        i_clear_faults, // clear faults pulse
  input  wire logic        i_run_cmd,      // run pin and operation on
  input  wire logic        i_fault,        // monitored fault, async
  input  wire logic [15:0] i_prop_events,  // events for the fault pin
  input  wire logic [15:0] i_retry_delay,  // retry interval, ms units
  output logic [7:0]       o_resp_rdata,   // response byte readback
  output logic [15:0]      o_mask_rdata,   // propagation mask readback
  output logic             o_fault_flag,   // latched status fault bit
  output logic             o_comm_memory_logic_fault, // sticky logic fault
  output logic             o_alert_n,      // alert, active low
  output logic             o_out_en,       // output regulation enable
  output logic             o_fault_pin_n   // fault pin, active low
);

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= i_fault;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  logic [15:0] ev_meta_ff;
  logic [15:0] ev_sync_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ev_meta_ff <= 16'h0000;
      ev_sync_ff <= 16'h0000;
    end else begin
      ev_meta_ff <= i_prop_events;
      ev_sync_ff <= ev_meta_ff;
    end
  end

  wire fault_rise = sync_ff && !prev_ff;

  // --------------------------------------------------------------------
  // response setting register
  // --------------------------------------------------------------------
  logic [7:0] resp_ff;
  logic [7:0] nxt_resp;
  logic       logic_flt_ff;

  wire [1:0] wr_resp  =
    i_resp_wdata[frr_pkg::RESP_MSB:frr_pkg::RESP_LSB];
  wire [2:0] wr_retry =
    i_resp_wdata[frr_pkg::RETRY_MSB:frr_pkg::RETRY_LSB];
  wire resp_bad  = (wr_resp != frr_pkg::RESP_CONTINUE) &&
                   (wr_resp != frr_pkg::RESP_SHUTDOWN);
  wire retry_bad = (wr_retry != frr_pkg::RETRY_NONE) &&
                   (wr_retry != frr_pkg::RETRY_FOREVER);
  wire wr_bad    = i_resp_wr && (resp_bad || retry_bad);
  // delay field is stored for readback but never steers anything
  assign nxt_resp = (i_resp_wr && !wr_bad) ? i_resp_wdata : resp_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      resp_ff      <= frr_pkg::RESP_RESET;
      logic_flt_ff <= 1'b0;
    end else begin
      resp_ff <= nxt_resp;
      // set wins over a simultaneous clear
      if (wr_bad) begin
        logic_flt_ff <= 1'b1;
      end else if (i_clear_faults) begin
        logic_flt_ff <= 1'b0;
      end
    end
  end

  wire [1:0] resp_code  = resp_ff[frr_pkg::RESP_MSB:frr_pkg::RESP_LSB];
  wire [2:0] retry_code = resp_ff[frr_pkg::RETRY_MSB:frr_pkg::RETRY_LSB];
  wire do_shutdown = (resp_code == frr_pkg::RESP_SHUTDOWN);
  wire do_retry    = (retry_code == frr_pkg::RETRY_FOREVER);

  // --------------------------------------------------------------------
  // propagation mask
  // --------------------------------------------------------------------
  logic [15:0] mask_ff;
  wire mask_wr = i_cmd_wr && (i_cmd_code == frr_pkg::CMD_PROP_MASK);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mask_ff <= frr_pkg::PROP_MASK_RESET;
    end else if (i_nvm_load) begin
      mask_ff <= i_nvm_mask;
    end else if (mask_wr) begin
      mask_ff <= i_cmd_wdata;
    end
  end

  // --------------------------------------------------------------------
  // off/on cycle detect
  // --------------------------------------------------------------------
  logic run_prev_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      // idle level of the run input, so reset makes no false turn-on
      run_prev_ff <= 1'b1;
    end else begin
      run_prev_ff <= i_run_cmd;
    end
  end
  wire run_rise = i_run_cmd && !run_prev_ff;

  // --------------------------------------------------------------------
  // latched fault flag and alert
  // --------------------------------------------------------------------
  logic flag_ff;
  logic alert_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flag_ff  <= 1'b0;
      alert_ff <= 1'b0;
    end else begin
      if (fault_rise) begin
        flag_ff  <= 1'b1;
        alert_ff <= 1'b1;
      end else if (i_clear_faults || run_rise) begin
        flag_ff  <= 1'b0;
        // a refused write in the same cycle keeps the alert up
        alert_ff <= wr_bad || (logic_flt_ff && !i_clear_faults);
      end else if (wr_bad) begin
        alert_ff <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // retry delay unit tick
  // --------------------------------------------------------------------
  logic [15:0] div_ff;
  logic        tick_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (div_ff == 16'(frr_pkg::RETRY_UNIT_CYC - 1)) begin
      div_ff  <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // output state machine
  // --------------------------------------------------------------------
  frr_pkg::frr_state_e state_ff;
  frr_pkg::frr_state_e nxt_state;
  logic                timer_done;
  wire                 start_wait;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      frr_pkg::FRR_RUN: begin
        // continue code leaves regulation untouched
        if (fault_rise && do_shutdown) begin
          nxt_state = do_retry ? frr_pkg::FRR_WAIT
                               : frr_pkg::FRR_OFF;
        end
      end
      frr_pkg::FRR_OFF: begin
        if (i_clear_faults || run_rise) begin
          nxt_state = frr_pkg::FRR_RUN;
        end
      end
      frr_pkg::FRR_WAIT: begin
        if (!i_run_cmd || i_clear_faults) begin
          nxt_state = frr_pkg::FRR_RUN;
        end else if (!do_retry) begin
          nxt_state = frr_pkg::FRR_OFF;
        end else if (timer_done) begin
          nxt_state = frr_pkg::FRR_RUN;
        end
      end
      default: nxt_state = frr_pkg::FRR_RUN;
    endcase
  end

  assign start_wait = (state_ff != frr_pkg::FRR_WAIT) &&
                      (nxt_state == frr_pkg::FRR_WAIT);

  frr_retry_timer u_retry (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_load      (start_wait),
    .i_units     (i_retry_delay),
    .i_unit_tick (tick_ff),
    .o_done      (timer_done)
  );

  logic out_en_ff;
  logic pin_n_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_ff  <= frr_pkg::FRR_RUN;
      out_en_ff <= 1'b0;
      pin_n_ff  <= 1'b1;
    end else begin
      state_ff  <= nxt_state;
      out_en_ff <= i_run_cmd && (nxt_state == frr_pkg::FRR_RUN);
      pin_n_ff  <= ~(|(mask_ff & ev_sync_ff));
    end
  end

  assign o_resp_rdata  = resp_ff;
  assign o_mask_rdata  = mask_ff;
  assign o_fault_flag  = flag_ff;
  assign o_comm_memory_logic_fault = logic_flt_ff;
  assign o_alert_n     = ~alert_ff;
  assign o_out_en      = out_en_ff;
  assign o_fault_pin_n = pin_n_ff;

endmodule

// ===== bench/frr_host_model.sv
// Purpose: host side model, issues writes, clears and run changes
// Assumes: bench calls its tasks; strobes last one clock
// Notes:   write data is inverted once the strobe has gone
`timescale 1ns/100ps
module frr_host_model (
  input  wire logic        i_ref_clk,    // clock
  output logic             o_resp_wr,    // response write
  output logic [7:0]       o_resp_wdata, // response data
  output logic             o_cmd_wr,     // word write
  output logic [7:0]       o_cmd_code,   // command code
  output logic [15:0]      o_cmd_wdata,  // word data
  output logic             o_clear,      // clear faults
  output logic             o_run         // run and on
);
  initial begin
    {o_resp_wr, o_cmd_wr, o_clear} = 3'h0;
    {o_resp_wdata, o_cmd_code, o_cmd_wdata} = 32'h0;
    o_run = 1'b1;
  end

  task automatic wr_resp(input logic [7:0] b);
    @(negedge i_ref_clk);
    o_resp_wr = 1'b1;
    o_resp_wdata = b;
    @(negedge i_ref_clk);
    o_resp_wr = 1'b0;
    o_resp_wdata = ~b;
  endtask

  task automatic wr_cmd(input logic [7:0] c, input logic [15:0] w);
    @(negedge i_ref_clk);
    o_cmd_wr = 1'b1;
    o_cmd_code = c;
    o_cmd_wdata = w;
    @(negedge i_ref_clk);
    o_cmd_wr = 1'b0;
    o_cmd_wdata = ~w;
  endtask

  task automatic clear();
    @(negedge i_ref_clk);
    o_clear = 1'b1;
    @(negedge i_ref_clk);
    o_clear = 1'b0;
  endtask

  task automatic set_run(input logic v);
    @(negedge i_ref_clk);
    o_run = v;
  endtask
endmodule

// ===== bench/frr_fault_ctrl_monitor.sv
// Purpose: port checker for the fault response block
// Assumes: one clock, sync reset
// Notes:   attached to every instance by bind
`timescale 1ns/100ps
module frr_fault_ctrl_monitor (
  input wire logic        i_ref_clk,      // clock
  input wire logic        i_rst,          // reset
  input wire logic        i_resp_wr,      // response write
  input wire logic [7:0]  i_resp_wdata,   // response data
  input wire logic        i_clear_faults, // clear faults
  input wire logic        i_run_cmd,      // run
  input wire logic        i_fault,        // fault
  input wire logic [7:0]  o_resp_rdata,   // response readback
  input wire logic [15:0] o_mask_rdata,   // mask readback
  input wire logic        o_fault_flag,   // latched flag
  input wire logic        o_comm_memory_logic_fault, // logic fault flag
  input wire logic        o_alert_n,      // alert
  input wire logic        o_out_en        // output enable
);
  wire logic [2:0] try_w = i_resp_wdata[5:3];
  // codes 01 and 11 both carry bit 6
  wire logic       bad_w = i_resp_wdata[6] | (try_w != 3'h0 && try_w != 3'h7);

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  reset_vals_a: assert property (disable iff (1'b0) i_rst |=>
    o_resp_rdata == 8'h80 && o_mask_rdata == 16'h2993 && !o_fault_flag
    && !o_comm_memory_logic_fault && o_alert_n && !o_out_en)
    else $error("reset value");
  bad_code_a: assert property (i_resp_wr && bad_w |=>
    o_comm_memory_logic_fault && $stable(o_resp_rdata))
    else $error("bad code kept");
  good_code_a: assert property (i_resp_wr && !bad_w |=>
    o_resp_rdata == $past(i_resp_wdata)) else $error("code lost");
  flag_set_a: assert property ($rose(i_fault) |->
    ##[2:5] o_fault_flag) else $error("flag late");
  alert_set_a: assert property ($rose(o_fault_flag) |->
    !o_alert_n) else $error("no alert");
  flag_hold_a: assert property ($fell(o_fault_flag) |->
    $past(i_clear_faults) || $past(i_run_cmd) && !$past(i_run_cmd, 2)
    || $past(i_run_cmd, 2) && !$past(i_run_cmd, 3)) else $error("flag lost");
  cont_run_a: assert property (o_resp_rdata[7:6] == 2'h0 && o_out_en
    && i_run_cmd |=> o_out_en) else $error("continue stopped");
  shut_off_a: assert property ($rose(o_fault_flag)
    && o_resp_rdata[7:6] == 2'h2 |-> !o_out_en) else $error("no shutdown");
  off_stays_a: assert property (o_fault_flag && !o_out_en
    && o_resp_rdata[5:3] == 3'h0 && !i_clear_faults && !$past(i_clear_faults)
    && $stable(i_run_cmd) && i_run_cmd == $past(i_run_cmd, 2) |=> !o_out_en)
    else $error("restarted");
endmodule

bind frr_fault_ctrl frr_fault_ctrl_monitor mon (.*);

// ===== bench/frr_fault_ctrl_tb.sv
// Purpose: self-checking bench for the fault response block
// Assumes: host model drives the command side
// Notes:   a 1 ms retry delay keeps the run short
`timescale 1ns/100ps
module frr_fault_ctrl_tb;
  logic        clk = 1'b0;
  logic        rst;
  logic        fault;
  logic        nvm_ld;
  logic [15:0] nvm_mask;
  logic [15:0] events;
  logic [15:0] delay;
  logic        resp_wr, cmd_wr, clr, run, flag, lflt, alert_n, out_en, pin_n;
  logic [7:0]  resp_wd, cmd_code, resp_rd;
  logic [15:0] cmd_wd, mask_rd;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;

  frr_host_model host (.i_ref_clk(clk), .o_resp_wr(resp_wr),
    .o_resp_wdata(resp_wd), .o_cmd_wr(cmd_wr), .o_cmd_code(cmd_code),
    .o_cmd_wdata(cmd_wd), .o_clear(clr), .o_run(run));
  frr_fault_ctrl uut (.i_ref_clk(clk), .i_rst(rst), .i_resp_wr(resp_wr),
    .i_resp_wdata(resp_wd), .i_cmd_wr(cmd_wr), .i_cmd_code(cmd_code),
    .i_cmd_wdata(cmd_wd), .i_nvm_load(nvm_ld), .i_nvm_mask(nvm_mask),
    .i_clear_faults(clr), .i_run_cmd(run), .i_fault(fault),
    .i_prop_events(events), .i_retry_delay(delay), .o_resp_rdata(resp_rd),
    .o_mask_rdata(mask_rd), .o_fault_flag(flag),
    .o_comm_memory_logic_fault(lflt),
    .o_alert_n(alert_n), .o_out_en(out_en), .o_fault_pin_n(pin_n));

  initial forever #50 clk = ~clk;
  // ceiling sits well above the longest retry wait
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic hit();
    @(negedge clk);
    fault = 1'b1;
    repeat (7) @(negedge clk);
    fault = 1'b0;
  endtask

  task automatic t_codes();
    logic [7:0] bad [8] = '{8'h40, 8'hC0, 8'h88, 8'h90, 8'h98, 8'hA0,
                            8'hA8, 8'hB0};
    chk({resp_rd, 6'h0, lflt, alert_n}, 16'h8001);
    chk(mask_rd, 16'h2993);
    foreach (bad[i]) begin
      host.wr_resp(bad[i]);
      @(negedge clk);
      chk({resp_rd, 6'h0, lflt, alert_n}, 16'h8002);
      host.clear();
    end
    host.wr_resp(8'h3F);
    @(negedge clk);
    chk({resp_rd[7:3], lflt}, 6'h0E);
  endtask

  task automatic t_mask();
    host.wr_cmd(8'hD2, 16'h0001);
    host.wr_cmd(8'hD3, 16'hFFFF);
    @(negedge clk);
    chk(mask_rd, 16'h0001);
    events = 16'h0002;
    repeat (5) @(negedge clk);
    chk(pin_n, 1'b1);
    events = 16'h0003;
    repeat (5) @(negedge clk);
    chk(pin_n, 1'b0);
    events = 16'h0000;
    nvm_mask = 16'h5A5A;
    nvm_ld = 1'b1;
    @(negedge clk);
    nvm_ld = 1'b0;
    @(negedge clk);
    chk(mask_rd, 16'h5A5A);
  endtask

  task automatic t_cont_shut();
    host.wr_resp(8'h07);
    hit();
    chk({flag, alert_n, out_en}, 3'b101);
    host.clear();
    @(negedge clk);
    chk({flag, alert_n}, 2'b01);
    host.wr_resp(8'h80);
    hit();
    chk({flag, alert_n, out_en}, 3'b100);
    repeat (300) @(negedge clk);
    chk({flag, out_en}, 2'b10);
    host.set_run(1'b0);
    host.set_run(1'b1);
    repeat (4) @(negedge clk);
    chk({flag, out_en}, 2'b01);
  endtask

  task automatic t_retry();
    int n;
    host.wr_resp(8'hB8);
    hit();
    chk(out_en, 1'b0);
    for (n = 0; n < 25000 && !out_en; n++) @(negedge clk);
    // one 1 ms unit plus at most one unit of tick phase
    chk(16'(n >= 9990 && n <= 20010), 16'h0001);
    chk(flag, 1'b1);
    delay = 16'h0000;
    hit();
    for (n = 0; n < 25000 && !out_en; n++) @(negedge clk);
    // a zero interval still waits for the next unit tick
    chk(16'(n <= 10010), 16'h0001);
    hit();
    host.set_run(1'b0);
    repeat (25000) @(negedge clk);
    chk(out_en, 1'b0);
    host.wr_resp(8'h80);
    host.clear();
    host.set_run(1'b1);
  endtask

  initial begin
    rst = 1'b1;
    fault = 1'b0;
    nvm_ld = 1'b0;
    nvm_mask = 16'h2993;
    events = 16'h0000;
    delay = 16'h0001;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_codes();
    t_mask();
    t_cont_shut();
    t_retry();
    end_sim();
  end
endmodule
